// [common/gss_pkg.sv]
// package: register map, field positions, modes and timing for the gain set selector
package gss_pkg;
  // register offsets (object indices)
  localparam logic [15:0] GSS_ADDR_CMD_ONE = 16'h2d01;
  localparam logic [15:0] GSS_ADDR_CMD_FIVE = 16'h2d05;
  localparam logic [15:0] GSS_ADDR_STAT_ONE = 16'h2d11;
  localparam logic [15:0] GSS_ADDR_STAT_FIVE = 16'h2d15;
  localparam logic [15:0] GSS_ADDR_CFG = 16'h2e00;
  localparam logic [15:0] GSS_ADDR_THR_ONE = 16'h2e01;
  localparam logic [15:0] GSS_ADDR_THR_TWO = 16'h2e02;
  localparam logic [15:0] GSS_ADDR_TC_ONE = 16'h2e03;
  localparam logic [15:0] GSS_ADDR_TC_TWO = 16'h2e04;
  localparam logic [15:0] GSS_ADDR_GAIN_BASE = 16'h2e05;
  localparam logic [15:0] GSS_ADDR_GAIN_ONE = 16'h2e06;
  localparam logic [15:0] GSS_ADDR_GAIN_TWO = 16'h2e07;
  localparam logic [15:0] GSS_ADDR_GAIN_OUT = 16'h2e08;
  // field positions
  localparam int GSS_SWITCH_BIT = 4;
  localparam int GSS_CFG_SRC_LSB = 0;
  localparam int GSS_CFG_POL_BIT = 4;
  localparam int GSS_CFG_SRC2_LSB = 8;
  // reset values
  localparam logic [15:0] GSS_CFG_RST = 16'h0000;
  localparam logic [15:0] GSS_THR_RST = 16'h0000;
  localparam logic [15:0] GSS_TC_RST = 16'h0000;
  localparam logic [15:0] GSS_GAIN_RST = 16'h0000;
  // first switching source field
  localparam logic [3:0] GSS_SRC_DISABLED = 4'h0;
  localparam logic [3:0] GSS_SRC_SIGNAL = 4'h1;
  localparam logic [3:0] GSS_SRC_SPEED = 4'h4;
  // second switching source field
  localparam logic [3:0] GSS_SRC2_DISABLED = 4'h0;
  localparam logic [3:0] GSS_SRC2_SIGNAL = 4'h1;
  localparam logic [3:0] GSS_SRC2_SAME = 4'h2;
  // filter: time constant unit is one filter tick
  localparam int GSS_TICK_NS = 1000;
  localparam int GSS_CLK_NS = 50;
  localparam int GSS_TICK_CYC = (GSS_TICK_NS + GSS_CLK_NS - 1) / GSS_CLK_NS;
  localparam int GSS_FRAC = 16;
  // selected set
  typedef enum logic [2:0] {
    GSS_SET_BASE = 3'b001,
    GSS_SET_ONE = 3'b010,
    GSS_SET_TWO = 3'b100
  } gss_set_t;
endpackage : gss_pkg

// [rtl/gss_speed_cmp.sv]
// speed comparator: registered flags of absolute speed against one threshold
`timescale 1ns/1ns
module gss_speed_cmp (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // operands
  input wire logic [15:0] abs_speed_i,
  input wire logic [15:0] threshold_i,
  // flags
  output logic above_o,
  output logic below_o
);
  import gss_pkg::*;
  typedef struct packed {
    logic above;
    logic below;
  } gss_cmp_state_t;
  gss_cmp_state_t s_q, s_d;
  always_comb begin
    s_d.above = abs_speed_i > threshold_i;
    s_d.below = abs_speed_i < threshold_i;
  end
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign above_o = s_q.above;
  assign below_o = s_q.below;
endmodule : gss_speed_cmp

// [rtl/gss_lag_filter.sv]
// first-order lag filter stepping a gain value toward its target
`timescale 1ns/1ns
module gss_lag_filter (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic tick_i,
  input wire logic [15:0] time_const_i,
  input wire logic [15:0] target_i,
  // result
  output logic [15:0] value_o
);
  import gss_pkg::*;
  typedef struct packed {
    logic [16+GSS_FRAC-1:0] acc;
  } gss_flt_state_t;
  gss_flt_state_t s_q, s_d;
  logic signed [33:0] diff;
  logic signed [33:0] step;
  always_comb begin
    s_d = s_q;
    diff = $signed({2'b00, target_i, {GSS_FRAC{1'b0}}}) - $signed({2'b00, s_q.acc});
    step = (time_const_i == 16'h0000) ? diff : diff / $signed({18'h0, time_const_i});
    // step of diff/tc per tick gives 1-(1-1/tc)^tc, 63.2 percent or more, after tc ticks; reverses with the sign of diff
    if (tick_i) begin
      if (time_const_i == 16'h0000 || step == 34'sd0) begin
        s_d.acc = {target_i, {GSS_FRAC{1'b0}}};
      end else begin
        s_d.acc = 32'($signed({2'b00, s_q.acc}) + step);
      end
    end
  end
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign value_o = s_q.acc[16+GSS_FRAC-1:GSS_FRAC];
endmodule : gss_lag_filter

// [rtl/gss_selector.sv]
// gain set selector: mode decode, register port, status and filtered gain output
`timescale 1ns/1ns
module gss_selector (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [15:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // motion inputs
  input wire logic [15:0] abs_speed_i,
  input wire logic input_gain_switch_one_i,
  input wire logic input_gain_switch_two_i,
  // selection and gain outputs
  output gss_pkg::gss_set_t active_set_o,
  output logic stat_gain_set_one_active_o,
  output logic stat_gain_set_two_active_o,
  output logic [15:0] model_gain_o
);
  import gss_pkg::*;

  typedef struct packed {
    logic [15:0] cmd_one;
    logic [15:0] cmd_five;
    logic [15:0] cfg;
    logic [15:0] thr_one;
    logic [15:0] thr_two;
    logic [15:0] tc_one;
    logic [15:0] tc_two;
    logic [15:0] gain_base;
    logic [15:0] gain_one;
    logic [15:0] gain_two;
    logic sw_one;
    logic sw_two;
    gss_set_t set;
    logic [15:0] tc_sel;
    logic [15:0] target;
    logic [7:0] tick_cnt;
    logic tick;
    logic [15:0] rdata;
    logic [15:0] gain_out;
  } gss_state_t;

  gss_state_t s_q, s_d;
  logic above_one, below_one, above_two, below_two;
  logic [15:0] flt_value;
  logic [3:0] src, src2;
  logic pol;
  logic sig_one, sig_two, speed_pair;
  gss_set_t nxt_set;

  gss_speed_cmp u_cmp_one (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .abs_speed_i(abs_speed_i),
    .threshold_i(s_q.thr_one),
    .above_o(above_one),
    .below_o(below_one)
  );

  gss_speed_cmp u_cmp_two (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .abs_speed_i(abs_speed_i),
    .threshold_i(s_q.thr_two),
    .above_o(above_two),
    .below_o(below_two)
  );

  gss_lag_filter u_flt (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .tick_i(s_q.tick),
    .time_const_i(s_q.tc_sel),
    .target_i(s_q.target),
    .value_o(flt_value)
  );

  always_comb begin
    s_d = s_q;
    src = s_q.cfg[GSS_CFG_SRC_LSB +: 4];
    src2 = s_q.cfg[GSS_CFG_SRC2_LSB +: 4];
    pol = s_q.cfg[GSS_CFG_POL_BIT];
    speed_pair = src == GSS_SRC_SPEED && src2 == GSS_SRC2_SAME && s_q.thr_two != 16'h0000;
    // registered switch sources: command bit or input device
    s_d.sw_one = s_q.cmd_one[GSS_SWITCH_BIT] | input_gain_switch_one_i;
    s_d.sw_two = s_q.cmd_five[GSS_SWITCH_BIT] | input_gain_switch_two_i;
    sig_one = s_q.sw_one ^ pol;
    sig_two = s_q.sw_two;
    nxt_set = GSS_SET_BASE;
    if (src == GSS_SRC_SIGNAL) begin
      // the second stage wins over the first when both are asserted
      if (src2 != GSS_SRC2_DISABLED && sig_two) begin
        nxt_set = GSS_SET_TWO;
      end else if (sig_one) begin
        nxt_set = GSS_SET_ONE;
      end
    end else if (src == GSS_SRC_SPEED) begin
      if (src2 == GSS_SRC2_SIGNAL) begin
        if (sig_two) begin
          nxt_set = GSS_SET_TWO;
        end else if (pol ? below_one : above_one) begin
          nxt_set = GSS_SET_ONE;
        end
      end else if (src2 == GSS_SRC2_SAME && s_q.thr_two != 16'h0000) begin
        if (!pol) begin
          if (s_q.thr_two >= s_q.thr_one) begin
            if (above_two) begin
              nxt_set = GSS_SET_TWO;
            end else if (above_one) begin
              nxt_set = GSS_SET_ONE;
            end
          end else if (above_two) begin
            nxt_set = GSS_SET_TWO;
          end
        end else begin
          if (s_q.thr_two <= s_q.thr_one) begin
            if (below_two) begin
              nxt_set = GSS_SET_TWO;
            end else if (below_one) begin
              nxt_set = GSS_SET_ONE;
            end
          end else if (below_two) begin
            nxt_set = GSS_SET_TWO;
          end
        end
      end else begin
        // zero second threshold or second stage off: first threshold alone
        if (pol ? below_one : above_one) begin
          nxt_set = GSS_SET_ONE;
        end
      end
    end
    s_d.set = nxt_set;
    unique case (s_q.set)
      GSS_SET_ONE: begin
        s_d.target = s_q.gain_one;
        s_d.tc_sel = s_q.tc_one;
      end
      GSS_SET_TWO: begin
        s_d.target = s_q.gain_two;
        s_d.tc_sel = s_q.tc_two;
      end
      GSS_SET_BASE: begin
        // returning to base keeps the stage constant that was last in use, or takes the stage one constant if that one is zero
        s_d.target = s_q.gain_base;
        s_d.tc_sel = (s_q.tc_sel == 16'h0000) ? s_q.tc_one : s_q.tc_sel;
      end
      default: begin
        s_d.target = s_q.gain_base;
        s_d.tc_sel = s_q.tc_one;
      end
    endcase
    if (s_q.tick_cnt == 8'(GSS_TICK_CYC - 1)) begin
      s_d.tick_cnt = 8'h00;
      s_d.tick = 1'b1;
    end else begin
      s_d.tick_cnt = s_q.tick_cnt + 8'h01;
      s_d.tick = 1'b0;
    end
    s_d.gain_out = flt_value;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        GSS_ADDR_CMD_ONE: s_d.cmd_one = reg_wdata_i;
        GSS_ADDR_CMD_FIVE: s_d.cmd_five = reg_wdata_i;
        GSS_ADDR_CFG: s_d.cfg = reg_wdata_i;
        GSS_ADDR_THR_ONE: s_d.thr_one = reg_wdata_i;
        GSS_ADDR_THR_TWO: s_d.thr_two = reg_wdata_i;
        GSS_ADDR_TC_ONE: s_d.tc_one = reg_wdata_i;
        GSS_ADDR_TC_TWO: s_d.tc_two = reg_wdata_i;
        GSS_ADDR_GAIN_BASE: s_d.gain_base = reg_wdata_i;
        GSS_ADDR_GAIN_ONE: s_d.gain_one = reg_wdata_i;
        GSS_ADDR_GAIN_TWO: s_d.gain_two = reg_wdata_i;
        default: begin
        end
      endcase
    end
    s_d.rdata = 16'h0000;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        GSS_ADDR_CMD_ONE: s_d.rdata = s_q.cmd_one;
        GSS_ADDR_CMD_FIVE: s_d.rdata = s_q.cmd_five;
        GSS_ADDR_STAT_ONE: s_d.rdata = 16'(s_q.set == GSS_SET_ONE) << GSS_SWITCH_BIT;
        GSS_ADDR_STAT_FIVE: s_d.rdata = 16'(s_q.set == GSS_SET_TWO) << GSS_SWITCH_BIT;
        GSS_ADDR_CFG: s_d.rdata = s_q.cfg;
        GSS_ADDR_THR_ONE: s_d.rdata = s_q.thr_one;
        GSS_ADDR_THR_TWO: s_d.rdata = s_q.thr_two;
        GSS_ADDR_TC_ONE: s_d.rdata = s_q.tc_one;
        GSS_ADDR_TC_TWO: s_d.rdata = s_q.tc_two;
        GSS_ADDR_GAIN_BASE: s_d.rdata = s_q.gain_base;
        GSS_ADDR_GAIN_ONE: s_d.rdata = s_q.gain_one;
        GSS_ADDR_GAIN_TWO: s_d.rdata = s_q.gain_two;
        GSS_ADDR_GAIN_OUT: s_d.rdata = s_q.gain_out;
        default: s_d.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.cfg <= GSS_CFG_RST;
      s_q.thr_one <= GSS_THR_RST;
      s_q.thr_two <= GSS_THR_RST;
      s_q.tc_one <= GSS_TC_RST;
      s_q.tc_two <= GSS_TC_RST;
      s_q.gain_base <= GSS_GAIN_RST;
      s_q.set <= GSS_SET_BASE;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o = s_q.rdata;
  assign active_set_o = s_q.set;
  // status flags decode straight from the set register, so they change with it
  assign stat_gain_set_one_active_o = s_q.set[1];
  assign stat_gain_set_two_active_o = s_q.set[2];
  assign model_gain_o = s_q.gain_out;

  // assertions
  cmd_priority_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (src == GSS_SRC_SIGNAL && src2 != GSS_SRC2_DISABLED && s_q.sw_two) |=> (s_q.set == GSS_SET_TWO))
    else $error("switch two command did not select set two");
  cmd_first_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (src == GSS_SRC_SIGNAL && !pol && $stable(s_q.cfg) && s_q.cmd_one[4] && !s_q.sw_two) |=> ##1 s_q.set != GSS_SET_BASE)
    else $error("switch one command did not leave base set");
  sig_gate_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (src == GSS_SRC_SIGNAL && !pol && !s_q.sw_one && !s_q.sw_two) |=> (s_q.set == GSS_SET_BASE))
    else $error("set changed without a switch signal");
  stat_one_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (reg_rd_i && reg_addr_i == GSS_ADDR_STAT_ONE) |=> (reg_rdata_o[4] == $past(stat_gain_set_one_active_o)))
    else $error("status one read mismatch");
  stat_two_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (reg_rd_i && reg_addr_i == GSS_ADDR_STAT_FIVE) |=> (reg_rdata_o[4] == $past(stat_gain_set_two_active_o)))
    else $error("status two read mismatch");
  speed_low_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (src == GSS_SRC_SPEED && src2 == GSS_SRC2_SAME && !pol && s_q.thr_two != 16'h0000
     && s_q.thr_two < s_q.thr_one) |=> (s_q.set != GSS_SET_ONE))
    else $error("set one chosen with low second threshold");
  speed_zero_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (src == GSS_SRC_SPEED && src2 == GSS_SRC2_SAME && s_q.thr_two == 16'h0000) |=> (s_q.set != GSS_SET_TWO))
    else $error("set two chosen with zero second threshold");
  speed_high_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (src == GSS_SRC_SPEED && src2 == GSS_SRC2_SAME && pol && s_q.thr_two > s_q.thr_one) |=> (s_q.set != GSS_SET_ONE))
    else $error("set one chosen with high second threshold");
  one_hot_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $onehot(s_q.set) && !(stat_gain_set_one_active_o && stat_gain_set_two_active_o))
    else $error("selected set not one-hot");
  // speed mode: antecedents follow the decode priority, as the flags lag a threshold write by one cycle
  speed_two_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (speed_pair && !pol && s_q.thr_two >= s_q.thr_one && above_two) |=> (s_q.set == GSS_SET_TWO))
    else $error("set two not chosen above second threshold");
  speed_one_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (speed_pair && !pol && s_q.thr_two >= s_q.thr_one && !above_two && above_one) |=> (s_q.set == GSS_SET_ONE))
    else $error("set one not chosen above first threshold");
  speed_idle_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (speed_pair && !pol && s_q.thr_two >= s_q.thr_one && !above_two && !above_one) |=> (s_q.set == GSS_SET_BASE))
    else $error("base set not kept below first threshold");
  low_two_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (speed_pair && !pol && s_q.thr_two < s_q.thr_one && above_two) |=> (s_q.set == GSS_SET_TWO))
    else $error("set two not chosen with low second threshold");
  band_two_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (speed_pair && pol && s_q.thr_two <= s_q.thr_one && below_two) |=> (s_q.set == GSS_SET_TWO))
    else $error("set two not chosen below second threshold");
  band_one_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (speed_pair && pol && s_q.thr_two <= s_q.thr_one && !below_two && below_one) |=> (s_q.set == GSS_SET_ONE))
    else $error("set one not chosen between thresholds");
  band_base_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (speed_pair && pol && s_q.thr_two <= s_q.thr_one && !below_two && !below_one) |=> (s_q.set == GSS_SET_BASE))
    else $error("base set not used at or above first threshold");
  high_two_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (speed_pair && pol && s_q.thr_two > s_q.thr_one && below_two) |=> (s_q.set == GSS_SET_TWO))
    else $error("set two not chosen with high second threshold");
  zero_one_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (src == GSS_SRC_SPEED && src2 == GSS_SRC2_SAME && s_q.thr_two == 16'h0000 && !pol && above_one)
    |=> (s_q.set == GSS_SET_ONE))
    else $error("set one not chosen with zero second threshold");
  zero_pol_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (src == GSS_SRC_SPEED && src2 == GSS_SRC2_SAME && s_q.thr_two == 16'h0000 && pol && below_one)
    |=> (s_q.set == GSS_SET_ONE))
    else $error("set one not chosen below first threshold");
  speed_sig_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (src == GSS_SRC_SPEED && src2 == GSS_SRC2_SIGNAL && s_q.sw_two) |=> (s_q.set == GSS_SET_TWO))
    else $error("switch two signal ignored in speed mode");
  first_only_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (src == GSS_SRC_SIGNAL && !pol && s_q.sw_one && !s_q.sw_two) |=> (s_q.set == GSS_SET_ONE))
    else $error("switch one alone did not select set one");
  inv_on_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (src == GSS_SRC_SIGNAL && pol && !s_q.sw_one && !s_q.sw_two) |=> (s_q.set == GSS_SET_ONE))
    else $error("inverted switch off did not select set one");
  inv_off_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (src == GSS_SRC_SIGNAL && pol && s_q.sw_one && (src2 == GSS_SRC2_DISABLED || !s_q.sw_two))
    |=> (s_q.set == GSS_SET_BASE))
    else $error("inverted switch on did not keep base set");
  // command bits and input devices reach the switch registers one cycle later
  sw_one_reg_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    s_q.sw_one == $past(s_q.cmd_one[GSS_SWITCH_BIT] | input_gain_switch_one_i))
    else $error("switch one register mismatch");
  sw_two_reg_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    s_q.sw_two == $past(s_q.cmd_five[GSS_SWITCH_BIT] | input_gain_switch_two_i))
    else $error("switch two register mismatch");
  stage_one_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (s_q.set == GSS_SET_ONE) |=> (s_q.target == $past(s_q.gain_one) && s_q.tc_sel == $past(s_q.tc_one)))
    else $error("stage one target or constant not latched");
  stage_two_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (s_q.set == GSS_SET_TWO) |=> (s_q.target == $past(s_q.gain_two) && s_q.tc_sel == $past(s_q.tc_two)))
    else $error("stage two target or constant not latched");
  base_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (s_q.set == GSS_SET_BASE && s_q.tc_sel != 16'h0000)
    |=> (s_q.target == $past(s_q.gain_base) && $stable(s_q.tc_sel)))
    else $error("base target or kept constant wrong");
  gain_path_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    model_gain_o == $past(flt_value))
    else $error("gain output does not follow the filter");
  tick_pulse_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    s_q.tick |=> !s_q.tick)
    else $error("filter tick longer than one cycle");
  tick_count_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    s_q.tick_cnt < 8'(GSS_TICK_CYC))
    else $error("tick counter out of range");
  rdata_idle_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !reg_rd_i |=> (reg_rdata_o == 16'h0000))
    else $error("read data not zero without a read");
endmodule : gss_selector

// [verification/gss_host_model.sv]
// host controller model: drives register writes and reads on the selector's port
`timescale 1ns/1ns
module gss_host_model (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // register port
  output logic [15:0] reg_addr_o,
  output logic [15:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire logic [15:0] reg_rdata_i
);
  initial begin
    reg_addr_o = 16'hffff;
    reg_wdata_o = 16'h0000;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end

  // released address and data are inverted so a stale value cannot look like a fresh request
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask : wr

  // read data stand only in the cycle after the strobe, taken at the edge that ends it
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge ref_clk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    @(posedge ref_clk_i);
    d = reg_rdata_i;
  endtask : rd
endmodule : gss_host_model

// [verification/gss_selector_tb_top.sv]
// testbench: register, signal, speed and filter scenarios for the gain set selector
`timescale 1ns/1ns
module gss_selector_tb_top;
  import gss_pkg::*;
  logic ref_clk_i;
  logic rst_n_i;
  logic [15:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic [15:0] abs_speed;
  logic sw_one;
  logic sw_two;
  gss_set_t active_set;
  logic st_one;
  logic st_two;
  logic [15:0] gain;
  logic [15:0] rv;
  int err_total;
  int total_checks;
  logic [15:0] tab [18][5];

  gss_selector DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .abs_speed_i(abs_speed),
    .input_gain_switch_one_i(sw_one), .input_gain_switch_two_i(sw_two), .active_set_o(active_set),
    .stat_gain_set_one_active_o(st_one), .stat_gain_set_two_active_o(st_two), .model_gain_o(gain));

  gss_host_model u_host (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_o(reg_addr),
    .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_rdata_i(reg_rdata));

  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_rng(input string what, input logic [15:0] lo, input logic [15:0] hi, input logic [15:0] got);
    total_checks++;
    if ((got inside {[lo:hi]}) !== 1'b1) begin
      err_total++;
      $display("[ERR] %s expected %h..%h seen %h", what, lo, hi, got);
    end
  endtask : chk_rng

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  function automatic logic [15:0] cfg(input logic [3:0] src, input logic pol, input logic [3:0] src2);
    return {4'h0, src2, 3'h0, pol, src};
  endfunction : cfg

  // set outputs and both status words must agree once the pipeline has settled
  task automatic expect_set(input logic [2:0] s);
    logic [15:0] r;
    repeat (6) @(posedge ref_clk_i);
    chk("active_set", {13'h0, s}, {13'h0, active_set});
    chk("stat_one_pin", {15'h0, s[1]}, {15'h0, st_one});
    chk("stat_two_pin", {15'h0, s[2]}, {15'h0, st_two});
    u_host.rd(GSS_ADDR_STAT_ONE, r);
    chk("status_word_one", {11'h0, s[1], 4'h0}, r);
    u_host.rd(GSS_ADDR_STAT_FIVE, r);
    chk("status_word_five", {11'h0, s[2], 4'h0}, r);
  endtask : expect_set

  task automatic drive(input logic [15:0] sp, input logic s1, input logic s2);
    @(posedge ref_clk_i);
    abs_speed <= sp;
    sw_one <= s1;
    sw_two <= s2;
  endtask : drive

  initial begin
    #2_000_000;
    err_total++;
    end_sim();
  end

  initial begin
    rst_n_i = 1'b0;
    abs_speed = 16'h0000;
    sw_one = 1'b0;
    sw_two = 1'b0;
    err_total = 0;
    total_checks = 0;
    // pol, first threshold, second threshold, speed, expected set
    tab = '{'{0, 100, 200, 50, 1}, '{0, 100, 200, 150, 2}, '{0, 100, 200, 250, 4}, '{0, 100, 0, 150, 2},
      '{0, 100, 0, 50, 1}, '{0, 100, 0, 9000, 2}, '{0, 100, 50, 80, 4}, '{0, 100, 50, 150, 4},
      '{0, 100, 50, 20, 1}, '{1, 100, 50, 20, 4}, '{1, 100, 50, 80, 2}, '{1, 100, 50, 150, 1},
      '{1, 100, 50, 100, 1}, '{1, 100, 0, 50, 2}, '{1, 100, 0, 150, 1}, '{1, 100, 200, 50, 4},
      '{1, 100, 200, 150, 4}, '{1, 100, 200, 250, 1}};
    repeat (4) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    // reset values and register access
    expect_set(3'b001);
    u_host.rd(GSS_ADDR_CFG, rv);
    chk("cfg_reset", GSS_CFG_RST, rv);
    u_host.rd(GSS_ADDR_THR_ONE, rv);
    chk("thr_one_reset", GSS_THR_RST, rv);
    u_host.wr(GSS_ADDR_STAT_ONE, 16'hffff);
    u_host.rd(16'h1234, rv);
    chk("unmapped_read", 16'h0000, rv);
    expect_set(3'b001);
    $display("test reset_regs done");
    // command bits with switching off, then in signal mode
    u_host.wr(GSS_ADDR_CMD_ONE, 16'h0010);
    expect_set(3'b001);
    u_host.wr(GSS_ADDR_CFG, cfg(GSS_SRC_SIGNAL, 1'b0, GSS_SRC2_SIGNAL));
    expect_set(3'b010);
    u_host.rd(GSS_ADDR_CMD_ONE, rv);
    chk("cmd_one_readback", 16'h0010, rv);
    u_host.wr(GSS_ADDR_CMD_FIVE, 16'h0010);
    expect_set(3'b100);
    u_host.wr(GSS_ADDR_CMD_ONE, 16'hffef);
    expect_set(3'b100);
    u_host.wr(GSS_ADDR_CMD_FIVE, 16'hffef);
    expect_set(3'b001);
    drive(16'h0000, 1'b1, 1'b0);
    expect_set(3'b010);
    drive(16'h0000, 1'b1, 1'b1);
    expect_set(3'b100);
    drive(16'h0000, 1'b0, 1'b0);
    u_host.wr(GSS_ADDR_CFG, cfg(GSS_SRC_SIGNAL, 1'b1, GSS_SRC2_SIGNAL));
    expect_set(3'b010);
    drive(16'h0000, 1'b1, 1'b0);
    expect_set(3'b001);
    drive(16'h0000, 1'b0, 1'b0);
    $display("test signal_mode done");
    // speed mode with the second stage on the same condition
    for (int i = 0; i < 18; i++) begin
      u_host.wr(GSS_ADDR_CFG, cfg(GSS_SRC_SPEED, tab[i][0][0], GSS_SRC2_SAME));
      u_host.wr(GSS_ADDR_THR_ONE, tab[i][1]);
      u_host.wr(GSS_ADDR_THR_TWO, tab[i][2]);
      drive(tab[i][3], 1'b0, 1'b0);
      expect_set(tab[i][4][2:0]);
    end
    // second stage on its own signal, then switched off: the first threshold alone decides
    u_host.wr(GSS_ADDR_CFG, cfg(GSS_SRC_SPEED, 1'b0, GSS_SRC2_SIGNAL));
    drive(16'd150, 1'b0, 1'b1);
    expect_set(3'b100);
    drive(16'd150, 1'b0, 1'b0);
    expect_set(3'b010);
    u_host.wr(GSS_ADDR_CFG, cfg(GSS_SRC_SPEED, 1'b0, GSS_SRC2_DISABLED));
    drive(16'd250, 1'b0, 1'b1);
    expect_set(3'b010);
    drive(16'h0000, 1'b0, 1'b0);
    $display("test speed_mode done");
    // transition filter: jump with zero constant, lag and reversal with four ticks
    u_host.wr(GSS_ADDR_CFG, cfg(GSS_SRC_SIGNAL, 1'b0, GSS_SRC2_DISABLED));
    u_host.wr(GSS_ADDR_GAIN_BASE, 16'h1000);
    u_host.wr(GSS_ADDR_GAIN_ONE, 16'h2000);
    repeat (30) @(posedge ref_clk_i);
    chk("gain_jump", 16'h1000, gain);
    u_host.wr(GSS_ADDR_TC_ONE, 16'h0004);
    u_host.wr(GSS_ADDR_CMD_ONE, 16'h0010);
    repeat (84) @(posedge ref_clk_i);
    chk_rng("gain_one_tc", 16'h1900, 16'h1c40, gain);
    repeat (1400) @(posedge ref_clk_i);
    chk_rng("gain_settled", 16'h1fe0, 16'h2000, gain);
    u_host.rd(GSS_ADDR_GAIN_OUT, rv);
    chk_rng("gain_out_reg", 16'h1fe0, 16'h2000, rv);
    u_host.wr(GSS_ADDR_CMD_ONE, 16'h0000);
    repeat (50) @(posedge ref_clk_i);
    chk_rng("gain_reverse", 16'h1001, 16'h1fdf, gain);
    // stage two keeps its own zero constant, so it jumps while stage one would still lag
    u_host.wr(GSS_ADDR_CFG, cfg(GSS_SRC_SIGNAL, 1'b0, GSS_SRC2_SIGNAL));
    u_host.wr(GSS_ADDR_GAIN_TWO, 16'h3000);
    u_host.wr(GSS_ADDR_CMD_FIVE, 16'h0010);
    repeat (30) @(posedge ref_clk_i);
    chk("gain_two_jump", 16'h3000, gain);
    $display("test filter done");
    end_sim();
  end
endmodule : gss_selector_tb_top
